// [include/lsfe_pkg.sv]
// package for the local bus slave front end: types and constants
package lsfe_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int LANES = 4;
   localparam int PWF_DEPTH = 64;
   localparam int RRF_DEPTH = 8;
   localparam logic [11:0] CFG_CYCLE_OFFSET = 12'h504;
   localparam logic PARITY_EVEN = 1'b0;
   localparam logic PARITY_RESET = PARITY_EVEN;
   localparam logic DIR_PCI = 1'b0;
   localparam int TA_LSB = 16;
   localparam int BS_W = 4;
   localparam int TA_W = 16;

   typedef enum logic [1:0] {
      LSFE_TGT_NONE,
      LSFE_TGT_REG,
      LSFE_TGT_CFG,
      LSFE_TGT_PCI
   } lsfe_target_e;

   typedef struct packed {
      logic posted_write_enable;
      logic prefetch_read_enable;
      logic pci_space_select;
      logic translate_enable;
      logic [BS_W-1:0] window_block_size;
      logic [TA_W-1:0] translation_address;
   } lsfe_image_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic burst;
      logic io_space;
      logic posted;
      logic prefetch;
      logic image;
      logic [LANES-1:0] byte_en;
   } lsfe_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [LANES-1:0] byte_en;
   } lsfe_word_s;
endpackage

// [logic/lsfe_fifo.sv]
// one-or-more-entry fifo with valid/ready on both sides
`timescale 1ns/10ps
module lsfe_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 2
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
   endfunction

   assign in_ready = (cnt_q != CW'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rp_q];
   assign level = cnt_q;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= inc(wp_q);
         if (pop) rp_q <= inc(rp_q);
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end
endmodule // lsfe_fifo

// [logic/lsfe_local_bus_slave_front_end.sv]
// local bus slave front end: claim, decode, parity, posted-write and read fifos
// Operation
// - parity travels in the same cycle as data
// - odd or even parity, even after reset
// - one parity line per byte lane
// - drive correct parity on read data
// - write parity mismatch sets error status
// - error irq gated by enable, routed by direction
// - writing one clears status and interrupt
// - parity error never alters the transfer
// - check only lanes carrying valid bytes
// - 64 by 32-bit posted-write fifo
// - delayed write blocks further posting until done
// - 32-byte read return fifo
// - claim on chip select, may lag strobe
// - register select decodes registers; 0x504 config
// - pci select claims; image select picks image
// - burst and direction pick pci cycle type
// - space bit picks memory or io
// - block size sets window up to 2 gbytes
// - translation substitutes upper address bits
// - posted-write enable posts single writes; bursts and disabled images use delayed write
// - prefetch enable prefetches full-word single reads; bursts always prefetch; else delayed read
// - size strap latched at reset picks protocol
`timescale 1ns/10ps
module lsfe_local_bus_slave_front_end
   import lsfe_pkg::*;
#(
   parameter int PWF_DEPTH_P = PWF_DEPTH,
   parameter int RRF_DEPTH_P = RRF_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   // local bus pins
   input wire logic address_strobe_n,
   input wire logic transfer_start_n,
   input wire logic register_chip_select_n,
   input wire logic pci_window_chip_select_n,
   input wire logic image_select,
   input wire logic burst_n,
   input wire logic read_write_n,
   input wire logic [LANES-1:0] byte_enable_n,
   input wire logic [ADDR_W-1:0] local_addr,
   input wire logic [DATA_W-1:0] local_data_in,
   input wire logic [LANES-1:0] lane_parity_lines_in,
   input wire logic size_strap_pin,
   output logic [DATA_W-1:0] local_data_out,
   output logic [LANES-1:0] lane_parity_lines_out,
   output logic local_data_oe,
   output logic transfer_ack_n,
   output logic local_interrupt_pin,
   output logic pci_interrupt_pin,
   // control and status
   input wire logic local_parity_polarity,
   input wire logic local_parity_error_irq_enable,
   input wire logic local_parity_error_irq_direction,
   input wire logic local_parity_error_clear,
   input wire lsfe_image_s image0_cfg,
   input wire lsfe_image_s image1_cfg,
   output logic local_parity_error_status,
   output logic protocol_transfer_start,
   output logic delayed_write_pending,
   // register channel side
   output logic reg_access_valid,
   output logic cfg_cycle_valid,
   output lsfe_req_s reg_access_req,
   output logic [DATA_W-1:0] reg_write_data,
   input wire logic reg_read_valid,
   input wire logic [DATA_W-1:0] reg_read_data,
   // pci master side
   output logic pci_req_valid,
   input wire logic pci_req_ready,
   output lsfe_req_s pci_req,
   output logic pwf_out_valid,
   input wire logic pwf_out_ready,
   output lsfe_word_s pwf_out,
   input wire logic delayed_write_done,
   input wire logic rrf_in_valid,
   output logic rrf_in_ready,
   input wire logic [DATA_W-1:0] rrf_in_data
);
   localparam int PWF_LW = $clog2(PWF_DEPTH_P+1);
   localparam int RRF_LW = $clog2(RRF_DEPTH_P+1);
   localparam int WORD_W = DATA_W + LANES;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CLAIM,
      ST_WRITE,
      ST_READ,
      ST_ACK
   } lsfe_state_e;

   // lane parity with the selected polarity
   function automatic logic [LANES-1:0] lane_parity(input logic [DATA_W-1:0] d,
                                                    input logic odd);
      logic [LANES-1:0] p;
      p = '0;
      for (int i = 0; i < LANES; i++) begin
         p[i] = (^d[i*8 +: 8]) ^ odd;
      end
      return p;
   endfunction

   // three-stage pin synchronisers; first stage feeds only the second
   logic [2:0] as_s_q, ts_s_q, csr_s_q, csp_s_q;
   wire as_act = !as_s_q[1] && !as_s_q[2];
   wire ts_act = !ts_s_q[1] && !ts_s_q[2];
   wire csr_act = !csr_s_q[1] && !csr_s_q[2];
   wire csp_act = !csp_s_q[1] && !csp_s_q[2];

   logic strap_done_q, proto_ts_q;
   lsfe_state_e st_q;
   lsfe_target_e tgt_q;
   lsfe_req_s req_q;
   logic [DATA_W-1:0] wdata_q;
   logic [LANES-1:0] wpar_q;
   logic perr_q, dw_pend_q, ack_n_q, oe_q;
   logic [DATA_W-1:0] dout_q;
   logic [LANES-1:0] pout_q;
   logic lirq_q, pirq_q, reg_v_q, cfg_v_q, pci_v_q;
   logic rd_pending_q;

   // strap caught by a clock after reset release
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_q <= 1'b0;
         proto_ts_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         proto_ts_q <= size_strap_pin;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         as_s_q <= 3'h7;
         ts_s_q <= 3'h7;
         csr_s_q <= 3'h7;
         csp_s_q <= 3'h7;
      end else begin
         as_s_q <= {as_s_q[1:0], address_strobe_n};
         ts_s_q <= {ts_s_q[1:0], transfer_start_n};
         csr_s_q <= {csr_s_q[1:0], register_chip_select_n};
         csp_s_q <= {csp_s_q[1:0], pci_window_chip_select_n};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decode and image settings
   wire strobe = proto_ts_q ? ts_act : as_act;
   wire lsfe_image_s img = image_select ? image1_cfg : image0_cfg;
   wire is_cfg = (local_addr[11:0] == CFG_CYCLE_OFFSET);
   wire lsfe_target_e dec_tgt = csr_act ? (is_cfg ? LSFE_TGT_CFG : LSFE_TGT_REG)
                                : (csp_act ? LSFE_TGT_PCI : LSFE_TGT_NONE);
   wire [LANES-1:0] be = ~byte_enable_n;
   wire single_word = burst_n && (be == {LANES{1'b1}});
   // window mask: block size n keeps 16+n low address bits
   wire [ADDR_W-1:0] keep_mask = ~({ADDR_W{1'b1}} << (TA_LSB + int'(img.window_block_size)));
   wire [ADDR_W-1:0] ta_full = {img.translation_address, {TA_LSB{1'b0}}};
   wire [ADDR_W-1:0] pci_addr = img.translate_enable ?
                                ((local_addr & keep_mask) | (ta_full & ~keep_mask))
                                : local_addr;

   wire lsfe_req_s new_req = '{
      addr: pci_addr,
      write: !read_write_n,
      burst: !burst_n,
      io_space: img.pci_space_select,
      posted: img.posted_write_enable && burst_n,
      prefetch: !burst_n || (img.prefetch_read_enable && single_word),
      image: image_select,
      byte_en: be
   };

   ////////////////////////////////////////////////////////////////////////////
   // fifos
   logic pwf_in_ready, rrf_out_valid, rrf_out_ready;
   logic [DATA_W-1:0] rrf_out_data;
   logic [WORD_W-1:0] pwf_out_raw;
   wire pwf_push = (st_q == ST_WRITE) && (tgt_q == LSFE_TGT_PCI);

   lsfe_fifo #(.WIDTH(WORD_W), .DEPTH(PWF_DEPTH_P)) u_posted_write_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(pwf_push),
      .in_ready(pwf_in_ready),
      .in_data({wdata_q, req_q.byte_en}),
      .out_valid(pwf_out_valid),
      .out_ready(pwf_out_ready),
      .out_data(pwf_out_raw),
      .level()
   );
   assign pwf_out = pwf_out_raw;

   lsfe_fifo #(.WIDTH(DATA_W), .DEPTH(RRF_DEPTH_P)) u_read_return_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(rrf_in_valid),
      .in_ready(rrf_in_ready),
      .in_data(rrf_in_data),
      .out_valid(rrf_out_valid),
      .out_ready(rrf_out_ready),
      .out_data(rrf_out_data),
      .level()
   );
   assign rrf_out_ready = (st_q == ST_READ) && (tgt_q == LSFE_TGT_PCI) && rd_pending_q;

   ////////////////////////////////////////////////////////////////////////////
   // parity check on written data, valid lanes only
   wire [LANES-1:0] lane_err = (lane_parity(wdata_q, local_parity_polarity) ^ wpar_q)
                               & req_q.byte_en;
   wire perr_set = (st_q == ST_WRITE) && (|lane_err);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         perr_q <= 1'b0;
      end else if (perr_set) begin
         perr_q <= 1'b1;
      end else if (local_parity_error_clear) begin
         perr_q <= 1'b0;
      end
   end

   // set wins over clear; irq follows status, steered by direction
   wire irq = perr_q && local_parity_error_irq_enable;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lirq_q <= 1'b0;
         pirq_q <= 1'b0;
      end else begin
         lirq_q <= irq && (local_parity_error_irq_direction != DIR_PCI);
         pirq_q <= irq && (local_parity_error_irq_direction == DIR_PCI);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transfer sequencer
   wire write_blocked = dw_pend_q || !pwf_in_ready;
   wire read_data_ok = (tgt_q == LSFE_TGT_PCI) ? (rd_pending_q && rrf_out_valid)
                                               : reg_read_valid;
   wire write_ok = (tgt_q == LSFE_TGT_PCI) ? (pwf_in_ready && pwf_push) : 1'b1;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         tgt_q <= LSFE_TGT_NONE;
         req_q <= '0;
         wdata_q <= '0;
         wpar_q <= '0;
         dw_pend_q <= 1'b0;
         ack_n_q <= 1'b1;
         oe_q <= 1'b0;
         dout_q <= '0;
         pout_q <= '0;
         reg_v_q <= 1'b0;
         cfg_v_q <= 1'b0;
         pci_v_q <= 1'b0;
         rd_pending_q <= 1'b0;
      end else begin
         reg_v_q <= 1'b0;
         cfg_v_q <= 1'b0;
         ack_n_q <= 1'b1;
         if (pci_v_q && pci_req_ready) pci_v_q <= 1'b0;
         if (delayed_write_done) dw_pend_q <= 1'b0;
         unique case (st_q)
            ST_IDLE, ST_CLAIM: begin
               oe_q <= 1'b0;
               // chip select may trail the strobe by decode wait states
               // req_q feeds pci_req, so no claim while a request still waits
               if (strobe && !pci_v_q && (dec_tgt != LSFE_TGT_NONE) &&
                   !(dec_tgt == LSFE_TGT_PCI && !read_write_n && write_blocked)) begin
                  tgt_q <= dec_tgt;
                  req_q <= new_req;
                  wdata_q <= local_data_in;
                  wpar_q <= lane_parity_lines_in;
                  if (dec_tgt == LSFE_TGT_PCI) begin
                     if (read_write_n) begin
                        pci_v_q <= 1'b1;
                        rd_pending_q <= 1'b1;
                     end else if (!new_req.posted) begin
                        dw_pend_q <= 1'b1;
                     end
                  end else begin
                     reg_v_q <= (dec_tgt == LSFE_TGT_REG);
                     cfg_v_q <= (dec_tgt == LSFE_TGT_CFG);
                  end
                  st_q <= read_write_n ? ST_READ : ST_WRITE;
               end else begin
                  st_q <= strobe ? ST_CLAIM : ST_IDLE;
               end
            end
            ST_WRITE: begin
               // errors only flag status; the write still completes
               if (write_ok) begin
                  if (tgt_q == LSFE_TGT_PCI) pci_v_q <= 1'b1;
                  ack_n_q <= 1'b0;
                  st_q <= ST_ACK;
               end
            end
            ST_READ: begin
               if (read_data_ok) begin
                  dout_q <= (tgt_q == LSFE_TGT_PCI) ? rrf_out_data : reg_read_data;
                  pout_q <= lane_parity((tgt_q == LSFE_TGT_PCI) ? rrf_out_data
                                        : reg_read_data, local_parity_polarity);
                  oe_q <= 1'b1;
                  ack_n_q <= 1'b0;
                  rd_pending_q <= 1'b0;
                  st_q <= ST_ACK;
               end
            end
            ST_ACK: begin
               // wait for the strobe to drop so one access is claimed once
               if (!strobe) st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   assign local_data_out = dout_q;
   assign lane_parity_lines_out = pout_q;
   assign local_data_oe = oe_q;
   assign transfer_ack_n = ack_n_q;
   assign local_interrupt_pin = lirq_q;
   assign pci_interrupt_pin = pirq_q;
   assign local_parity_error_status = perr_q;
   assign protocol_transfer_start = proto_ts_q;
   assign delayed_write_pending = dw_pend_q;
   assign reg_access_valid = reg_v_q;
   assign cfg_cycle_valid = cfg_v_q;
   assign reg_access_req = req_q;
   assign reg_write_data = wdata_q;
   assign pci_req_valid = pci_v_q;
   assign pci_req = req_q;
endmodule // lsfe_local_bus_slave_front_end

// [tb/lsfe_far_side_model.sv]
// pci master side model with random stalls, and register channel model with fixed read latency
`timescale 1ns/10ps
module lsfe_far_side_model
   import lsfe_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic stall_sink,
   input wire logic [DATA_W-1:0] rd_word,
   input wire logic pci_req_valid,
   input wire lsfe_req_s pci_req,
   output logic pci_req_ready,
   input wire logic pwf_out_valid,
   output logic pwf_out_ready,
   input wire logic delayed_write_pending,
   output logic delayed_write_done,
   output logic rrf_in_valid,
   input wire logic rrf_in_ready,
   output logic [DATA_W-1:0] rrf_in_data,
   input wire logic reg_access_valid,
   input wire logic cfg_cycle_valid,
   output logic reg_read_valid,
   output logic [DATA_W-1:0] reg_read_data
);
   logic [2:0] dw_q;
   logic [2:0] rr_q;
   // released data lines show the inverse, never a stale copy
   assign rrf_in_data = rrf_in_valid ? rd_word : ~rd_word;
   assign reg_read_valid = rr_q != 3'h0;
   assign reg_read_data = reg_read_valid ? rd_word : ~rd_word;
   assign delayed_write_done = dw_q == 3'h1;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {pci_req_ready, pwf_out_ready, rrf_in_valid, dw_q, rr_q} <= 9'h0;
      end else begin
         pci_req_ready <= 1'($urandom);
         pwf_out_ready <= !stall_sink && 1'($urandom);
         if (reg_access_valid || cfg_cycle_valid) rr_q <= 3'h4;
         else if (rr_q != 3'h0) rr_q <= rr_q - 3'h1;
         // delayed write completes a few cycles after its word leaves
         if (dw_q != 3'h0) dw_q <= dw_q - 3'h1;
         else if (pwf_out_valid && pwf_out_ready && delayed_write_pending) dw_q <= 3'h5;
         if (pci_req_valid && pci_req_ready && !pci_req.write) rrf_in_valid <= 1'b1;
         else if (rrf_in_ready) rrf_in_valid <= 1'b0;
      end
   end
endmodule // lsfe_far_side_model

// [tb/lsfe_front_end_asserts.sv]
// concurrent checks on the front end ports, bound into the design
`timescale 1ns/10ps
module lsfe_front_end_chk
   import lsfe_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic address_strobe_n,
   input wire logic transfer_start_n,
   input wire logic transfer_ack_n,
   input wire logic [DATA_W-1:0] local_data_out,
   input wire logic [LANES-1:0] lane_parity_lines_out,
   input wire logic local_data_oe,
   input wire logic local_parity_polarity,
   input wire logic local_parity_error_irq_enable,
   input wire logic local_parity_error_irq_direction,
   input wire logic local_parity_error_clear,
   input wire logic local_parity_error_status,
   input wire logic local_interrupt_pin,
   input wire logic pci_interrupt_pin,
   input wire logic cfg_cycle_valid,
   input wire lsfe_req_s reg_access_req,
   input wire logic pci_req_valid,
   input wire lsfe_req_s pci_req,
   input wire lsfe_image_s image0_cfg,
   input wire lsfe_image_s image1_cfg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] idle_q;
   // quiet bus time, so a clear is not racing a parity set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) idle_q <= 4'h0;
      else if (!address_strobe_n || !transfer_start_n) idle_q <= 4'h0;
      else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
   end
   ////////////////////////////////////////////////////////////
   property p_ack_claim;
      $fell(transfer_ack_n) |-> !$past(address_strobe_n, 4) || !$past(transfer_start_n, 4);
   endproperty
   a_ack_claim: assert property (p_ack_claim) else $error("ack without claim");
   property p_rd_par;
      !transfer_ack_n && local_data_oe |-> lane_parity_lines_out == ({^local_data_out[31:24],
         ^local_data_out[23:16], ^local_data_out[15:8], ^local_data_out[7:0]}
         ^ {4{local_parity_polarity}});
   endproperty
   a_rd_par: assert property (p_rd_par) else $error("read parity wrong");
   property p_sticky;
      local_parity_error_status && !local_parity_error_clear |=> local_parity_error_status;
   endproperty
   a_sticky: assert property (p_sticky) else $error("status dropped");
   property p_clear;
      local_parity_error_clear && idle_q > 4'h8 |=> !local_parity_error_status;
   endproperty
   a_clear: assert property (p_clear) else $error("status not cleared");
   property p_irq_route;
      (local_parity_error_status && local_parity_error_irq_enable && !local_parity_error_clear)
         [*2] ##0 $stable(local_parity_error_irq_direction) |->
         local_interrupt_pin == (local_parity_error_irq_direction != DIR_PCI) &&
         pci_interrupt_pin == (local_parity_error_irq_direction == DIR_PCI);
   endproperty
   a_irq_route: assert property (p_irq_route) else $error("irq pin wrong");
   property p_irq_off;
      !local_parity_error_irq_enable [*2] |-> !local_interrupt_pin && !pci_interrupt_pin;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   property p_cfg;
      cfg_cycle_valid |-> reg_access_req.addr[11:0] == CFG_CYCLE_OFFSET;
   endproperty
   a_cfg: assert property (p_cfg) else $error("config cycle offset wrong");
   property p_post;
      pci_req_valid && pci_req.write |-> pci_req.posted == (pci_req.image ?
         image1_cfg.posted_write_enable : image0_cfg.posted_write_enable);
   endproperty
   a_post: assert property (p_post) else $error("posting mode wrong");
endmodule // lsfe_front_end_chk

bind lsfe_local_bus_slave_front_end lsfe_front_end_chk u_chk (.ref_clk, .rst_n,
   .address_strobe_n, .transfer_start_n, .transfer_ack_n, .local_data_out,
   .lane_parity_lines_out, .local_data_oe, .local_parity_polarity,
   .local_parity_error_irq_enable, .local_parity_error_irq_direction,
   .local_parity_error_clear, .local_parity_error_status, .local_interrupt_pin,
   .pci_interrupt_pin, .cfg_cycle_valid, .reg_access_req, .pci_req_valid, .pci_req,
   .image0_cfg, .image1_cfg);

// [tb/lsfe_local_bus_slave_front_end_test.sv]
// self-checking bench for the local bus slave front end
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module lsfe_local_bus_slave_front_end_test
   import lsfe_pkg::*;
;
   logic ref_clk, rst_n, address_strobe_n, transfer_start_n, register_chip_select_n;
   logic pci_window_chip_select_n, image_select, burst_n, read_write_n, size_strap_pin;
   logic [LANES-1:0] byte_enable_n, lane_parity_lines_in, lane_parity_lines_out;
   logic [DATA_W-1:0] local_addr, local_data_in, local_data_out, reg_write_data;
   logic [DATA_W-1:0] reg_read_data, rrf_in_data, rd_word, e;
   logic local_data_oe, transfer_ack_n, local_interrupt_pin, pci_interrupt_pin;
   logic local_parity_polarity, local_parity_error_irq_enable, local_parity_error_irq_direction;
   logic local_parity_error_clear, local_parity_error_status, protocol_transfer_start;
   logic delayed_write_pending, reg_access_valid, cfg_cycle_valid, reg_read_valid;
   logic pci_req_valid, pci_req_ready, pwf_out_valid, pwf_out_ready, delayed_write_done;
   logic rrf_in_valid, rrf_in_ready, stall_sink;
   lsfe_image_s image0_cfg, image1_cfg;
   lsfe_req_s reg_access_req, pci_req;
   lsfe_word_s pwf_out;
   logic [DATA_W-1:0] rd_q[$], wr_q[$];
   int n_errors = 0, check_count = 0, n_cfg = 0;
   lsfe_local_bus_slave_front_end uut (.*);
   lsfe_far_side_model far (.*);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [3:0] par(logic [31:0] d, logic odd);
      for (int i = 0; i < 4; i++) par[i] = ^d[8*i +: 8] ^ odd;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic acc(input logic rs, im, wr, input logic [31:0] a, d, input logic [3:0] ben, flip);
      int t;
      {local_addr, local_data_in, byte_enable_n, image_select, read_write_n} = {a, d, ben, im, !wr};
      lane_parity_lines_in = par(d, local_parity_polarity) ^ flip;
      if (size_strap_pin) transfer_start_n = 1'b0;
      else address_strobe_n = 1'b0;
      repeat ($urandom_range(2)) tick(1); // cs may trail the strobe; lag 0 is dma timing
      register_chip_select_n = !rs;
      pci_window_chip_select_n = rs;
      for (t = 0; t < 300 && transfer_ack_n !== 1'b0; t++) tick(1);
      if (t == 300) begin
         n_errors++;
         $display("BAD ack exp 0 got %b", transfer_ack_n);
         summarize();
      end
      {address_strobe_n, transfer_start_n, register_chip_select_n, pci_window_chip_select_n} = 4'hf;
      local_data_in = ~d;
      lane_parity_lines_in = ~lane_parity_lines_in;
      tick(4);
   endtask
   task automatic wr_pci(input logic im, input logic [3:0] ben, flip);
      logic [31:0] d;
      d = $urandom;
      wr_q.push_back(d);
      acc(1'b0, im, 1'b1, $urandom, d, ben, flip);
   endtask
   task automatic rd(input logic rs, im, input logic [31:0] a);
      rd_word = $urandom;
      rd_q.push_back(rd_word);
      acc(rs, im, 1'b0, a, 32'h0, 4'h0, 4'h0);
   endtask
   // result watcher: oldest note against what appears
   always @(posedge ref_clk) begin
      if (transfer_ack_n === 1'b0 && local_data_oe === 1'b1 && rd_q.size() > 0) begin
         e = rd_q.pop_front();
         `CHK("rdata", e, local_data_out)
         `CHK("rpar", par(e, local_parity_polarity), lane_parity_lines_out)
      end
      if (pwf_out_valid === 1'b1 && pwf_out_ready === 1'b1 && wr_q.size() > 0) begin
         e = wr_q.pop_front();
         `CHK("wdata", e, pwf_out.data)
      end
      if (cfg_cycle_valid === 1'b1) n_cfg++;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      int c;
      logic [31:0] w;
      {address_strobe_n, transfer_start_n, register_chip_select_n, pci_window_chip_select_n} = 4'hf;
      {rst_n, image_select, read_write_n, size_strap_pin, local_parity_polarity} = 5'h0;
      {local_parity_error_irq_enable, local_parity_error_irq_direction} = 2'h0;
      {local_parity_error_clear, stall_sink, image0_cfg, image1_cfg, rd_word} = '0;
      {burst_n, byte_enable_n, local_addr, local_data_in, lane_parity_lines_in} = {1'b1, 72'h0};
      void'($urandom(20));
      for (int s = 0; s < 2; s++) begin
         size_strap_pin = s[0];
         rst_n = 1'b0;
         tick(2);
         rst_n = 1'b1;
         tick(5);
         `CHK("proto", s[0], protocol_transfer_start)
         for (int p = 0; p < 2; p++) begin
            local_parity_polarity = p[0];
            image0_cfg = lsfe_image_s'($urandom);
            image1_cfg = lsfe_image_s'($urandom);
            {image0_cfg.posted_write_enable, image1_cfg.posted_write_enable} = 2'b10;
            {image0_cfg.prefetch_read_enable, image1_cfg.prefetch_read_enable} = 2'b00;
            wr_pci(1'b0, 4'h0, 4'h0);
            wr_pci(1'b0, 4'h7, 4'h7); // bad parity only on unused lanes
            `CHK("perr_idle", 1'b0, local_parity_error_status)
            wr_pci(1'b1, 4'h7, 4'h8); // delayed write with a lane error
            wr_pci(1'b0, 4'h0, 4'h0); // held off until the delayed write ends
            `CHK("perr_set", 1'b1, local_parity_error_status)
            local_parity_error_irq_enable = 1'b1;
            for (int d = 0; d < 2; d++) begin
               local_parity_error_irq_direction = d[0];
               tick(3);
               `CHK("irq_loc", {d[0], !d[0]}, {local_interrupt_pin, pci_interrupt_pin})
            end
            local_parity_error_irq_enable = 1'b0;
            tick(3);
            `CHK("irq_off", 2'b00, {local_interrupt_pin, pci_interrupt_pin})
            rd(1'b1, 1'b0, {20'($urandom_range(255)), 12'h010});
            `CHK("perr_stick", 1'b1, local_parity_error_status)
            tick(8);
            local_parity_error_clear = 1'b1;
            tick(1);
            local_parity_error_clear = 1'b0;
            tick(2);
            `CHK("perr_clr", 1'b0, local_parity_error_status)
            c = n_cfg;
            rd(1'b1, 1'b0, {20'h0, CFG_CYCLE_OFFSET});
            `CHK("cfg", c + 1, n_cfg)
            w = $urandom;
            acc(1'b1, 1'b0, 1'b1, 32'h0000_0010, w, 4'h0, 4'h0);
            `CHK("regw", w, reg_write_data)
            rd(1'b0, 1'b1, $urandom); // delayed read through image 1
         end
         tick(100);
         stall_sink = 1'b1;
         repeat (PWF_DEPTH) wr_pci(1'b0, 4'h0, 4'h0);
         `CHK("fill", PWF_DEPTH, wr_q.size())
         stall_sink = 1'b0;
         tick(400);
         `CHK("drain", 0, wr_q.size() + rd_q.size())
      end
      summarize();
   end
endmodule // lsfe_local_bus_slave_front_end_test
